// ### core/idpw_ctrl.sv
// interleaved two-bank dram controller front end with write posting
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "idpw_defines.svh"

module idpw_ctrl (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// processor bus
	input wire logic addr_strobe_n_in,
	input wire logic [21:0] cpu_addr_in,
	input wire logic [3:0] cpu_be_n_in,
	input wire logic cpu_write_in,
	input wire logic cpu_line_in,
	input wire logic [31:0] cpu_wdata_in,
	output logic [31:0] cpu_rdata_out,
	output logic cycle_done_n_out,
	output logic burst_done_n_out,
	output logic addr_hold_en_out,
	output logic same_row_n_out,
	output logic data_sel_out,
	// dram banks
	input wire logic [31:0] bank0_rdata_in,
	input wire logic [31:0] bank1_rdata_in,
	output logic [1:0] row_strobe_n_out,
	output logic delayed_row_strobe_n_out,
	output logic [1:0] col_strobe_n_out,
	output logic write_en_n_out,
	output logic [3:0] dram_be_n_out,
	output logic [31:0] dram_wdata_out,
	output logic [8:0] bank0_addr_out,
	output logic [8:0] bank1_addr_out,
	output logic bank0_low_col_out,
	output logic bank1_low_col_out,
	output logic bank0_path_sel_n_out,
	output logic bank1_path_sel_n_out,
	output logic row_latch_en_out
);
	import idpw_pkg::*;

	localparam int DL = `IDPW_ROW_DLY_CYC;

	localparam idpw_s_t RST_S = '{
		ras_n: 2'h3, dly: {DL{1'b1}}, cdone_n: 1'b1, bdone_n: 1'b1, cas_n: 2'h3,
		we_n: 1'b1, be_n: 4'hf, path_n: 2'h3, same_n: 1'b1, st: ST_IDLE,
		cfg: `IDPW_CTRL_RST, default: '0};

	idpw_s_t s;
	idpw_s_t n;
	logic cap;
	logic [10:0] rrow;
	logic [10:0] wrow;
	logic [10:0] trow;
	logic hit;
	logic whit;
	logic wr_go;
	logic slot_free;
	logic [9:0] colv;

	////////////////////////////////////////////////////////////////////////////////
	// address decoding

	// {pair, row}; pair bit only when a second bank pair is fitted
	function automatic logic [10:0] idpw_row(input logic [21:0] a, input logic [1:0] cfg);
		logic pair;
		pair = 1'b0;
		if (cfg[`IDPW_CTRL_ORG_1M]) begin
			pair = a[21] & cfg[`IDPW_CTRL_TWO_PAIRS];
			return {pair, a[20:11]};
		end
		pair = a[19] & cfg[`IDPW_CTRL_TWO_PAIRS];
		return {pair, 1'b0, a[18:10]};
	endfunction : idpw_row

	function automatic logic [9:0] idpw_col(input logic [21:0] a, input logic [1:0] cfg);
		if (cfg[`IDPW_CTRL_ORG_1M]) begin
			return a[10:1];
		end
		return {1'b0, a[9:1]};
	endfunction : idpw_col

	// predicted address bit three for the next access that bank b serves
	function automatic logic idpw_pred(input logic a3, input logic a2, input logic b,
		input logic [1:0] cnt);
		logic [1:0] k;
		k = cnt + {1'b0, cnt[0] ^ a2 ^ b};
		return a3 ^ k[1];
	endfunction : idpw_pred

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		n = s;
		colv = '0;
		n.rle = 1'b0;
		n.cas_n = 2'h3;
		n.we_n = 1'b1;
		n.rd_cas = 1'b0;
		n.cdone_n = 1'b1;
		n.bdone_n = 1'b1;
		n.pready = 1'b0;
		n.path_n = 2'h3;

		cap = !addr_strobe_n_in && !s.hold_en;
		if (cap) begin
			n.hold_v = 1'b1;
			n.hold_wr = cpu_write_in;
			n.hold_line = cpu_line_in;
			n.hold_addr = cpu_addr_in;
			n.hold_be = ~cpu_be_n_in;
		end

		rrow = idpw_row(n.hold_addr, s.cfg);
		wrow = idpw_row(s.wr_addr, s.cfg);
		trow = s.wr_v ? wrow : rrow;
		hit = s.row_v && (rrow == s.row_reg) && !s.ras_n[rrow[10]];
		whit = s.row_v && (wrow == s.row_reg) && !s.ras_n[wrow[10]];
		n.same_n = !hit;
		wr_go = s.wr_v && (s.st == ST_IDLE) && whit;
		slot_free = !s.wr_v || (s.st == ST_WR) || wr_go;

		// posted write leaves the dram
		if (s.st == ST_WR) begin
			n.st = ST_IDLE;
			n.wr_v = 1'b0;
		end
		// data and column move to the posting registers on the done clock
		if (s.hold_v && s.hold_wr && !s.cdone_n) begin
			n.wr_v = 1'b1;
			n.wr_addr = s.hold_addr;
			n.wr_be = s.hold_be;
			n.wr_data = cpu_wdata_in;
			n.hold_v = 1'b0;
		end
		if (n.hold_v && n.hold_wr && s.cdone_n && slot_free) begin
			n.cdone_n = 1'b0;
		end

		unique case (s.st)
			ST_IDLE: begin
				if (s.wr_v) begin
					if (whit) begin
						n.st = ST_WR;
						n.cas_n[s.wr_addr[0]] = 1'b0;
						n.we_n = 1'b0;
						n.be_n = ~s.wr_be;
						n.path_n[s.wr_addr[0]] = 1'b0;
					end else begin
						n.st = ST_PRE;
						n.wait_c = 2'h0;
						n.ras_n = 2'h3;
						n.row_v = 1'b0;
					end
				end else if (n.hold_v && !n.hold_wr) begin
					if (hit) begin
						n.last = n.hold_line ? `IDPW_LINE_LAST : 2'h0;
						n.cnt = 2'h0;
						n.cas_n[n.hold_addr[0]] = 1'b0;
						n.dsel = n.hold_addr[0];
						n.rd_cas = 1'b1;
						n.be_n = 4'h0;
						if (n.last == 2'h0) begin
							n.hold_v = 1'b0;
						end else begin
							n.st = ST_RD;
						end
					end else begin
						n.st = ST_PRE;
						n.wait_c = 2'h0;
						n.ras_n = 2'h3;
						n.row_v = 1'b0;
					end
				end
			end
			ST_PRE: begin
				if (s.wait_c == `IDPW_PRE_CYC) begin
					n.st = ST_ROW;
					n.ras_n[trow[10]] = 1'b0;
					n.row_reg = trow;
					n.row_v = 1'b1;
					n.rle = 1'b1;
				end else begin
					n.wait_c = s.wait_c + 2'h1;
				end
			end
			ST_ROW: begin
				if (!s.dly[DL-1]) begin
					n.st = ST_IDLE;
				end
			end
			ST_RD: begin
				// one access per clock, banks alternate
				n.cnt = s.cnt + 2'h1;
				n.dsel = ~s.dsel;
				n.cas_n[~s.dsel] = 1'b0;
				n.rd_cas = 1'b1;
				if (n.cnt == s.last) begin
					n.st = ST_IDLE;
					n.hold_v = 1'b0;
				end
			end
			ST_WR: begin
			end
		endcase

		// read data leaves the selected bank only
		if (s.rd_cas) begin
			n.rd_data = s.dsel ? bank1_rdata_in : bank0_rdata_in;
			n.bdone_n = 1'b0;
		end

		n.dly = {s.dly[DL-2:0], &s.ras_n};
		n.hold_en = n.hold_v || n.rd_cas;

		// address multiplexer per bank
		for (int b = 0; b < 2; b++) begin
			colv = !n.path_n[b] ? idpw_col(n.wr_addr, s.cfg) : idpw_col(n.hold_addr, s.cfg);
			if (n.dly[DL-1]) begin
				n.addr[b] = n.row_reg[9:1];
				n.low[b] = n.row_reg[0];
			end else if (!n.path_n[b]) begin
				n.addr[b] = colv[9:1];
				n.low[b] = n.wr_addr[1];
			end else begin
				n.addr[b] = colv[9:1];
				n.low[b] = idpw_pred(n.hold_addr[1], n.hold_addr[0], 1'(b), n.cnt);
			end
		end

		// apb register access, zero wait states; writes land on the pready edge
		if (psel_in && !penable_in) begin
			n.pready = 1'b1;
			n.pslverr = 1'b0;
			n.prdata = 32'h0;
			unique case (paddr_in)
				`IDPW_OFF_CTRL: begin
					if (!pwrite_in) begin
						n.prdata = {30'h0, s.cfg};
					end
				end
				`IDPW_OFF_STAT: begin
					n.prdata[`IDPW_STAT_HOLD] = s.hold_en;
					n.prdata[`IDPW_STAT_WPEND] = s.wr_v;
					n.prdata[`IDPW_STAT_ROWV] = s.row_v;
					n.prdata[`IDPW_STAT_BUSY] = (s.st != ST_IDLE);
				end
				default: begin
					n.pslverr = 1'b1;
				end
			endcase
		end
		if (psel_in && penable_in && s.pready && pwrite_in && paddr_in == `IDPW_OFF_CTRL) begin
			n.cfg = pwdata_in[1:0];
			n.row_v = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			s <= RST_S;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata_out = s.prdata;
	assign pready_out = s.pready;
	assign pslverr_out = s.pslverr;
	assign cpu_rdata_out = s.rd_data;
	assign cycle_done_n_out = s.cdone_n;
	assign burst_done_n_out = s.bdone_n;
	assign addr_hold_en_out = s.hold_en;
	assign same_row_n_out = s.same_n;
	assign data_sel_out = s.dsel;
	assign row_strobe_n_out = s.ras_n;
	assign delayed_row_strobe_n_out = s.dly[DL-1];
	assign col_strobe_n_out = s.cas_n;
	assign write_en_n_out = s.we_n;
	assign dram_be_n_out = s.be_n;
	assign dram_wdata_out = s.wr_data;
	assign bank0_addr_out = s.addr[0];
	assign bank1_addr_out = s.addr[1];
	assign bank0_low_col_out = s.low[0];
	assign bank1_low_col_out = s.low[1];
	assign bank0_path_sel_n_out = s.path_n[0];
	assign bank1_path_sel_n_out = s.path_n[1];
	assign row_latch_en_out = s.rle;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_wr_done;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(!addr_strobe_n_in && !s.hold_en && cpu_write_in && !s.wr_v) |=> !cycle_done_n_out;
	endproperty
	a_wr_done: assert property (p_wr_done) else $error("write done late");

	property p_wr_cas;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(!cycle_done_n_out && s.hold_wr && s.st == ST_IDLE && !s.wr_v && hit)
			|-> ##2 (col_strobe_n_out != 2'h3 && !write_en_n_out);
	endproperty
	a_wr_cas: assert property (p_wr_cas) else $error("posted write strobe misplaced");

	property p_wr_bank;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(s.st == ST_WR) |-> (!col_strobe_n_out[s.wr_addr[0]] && $stable(s.wr_addr));
	endproperty
	a_wr_bank: assert property (p_wr_bank) else $error("write bank or column wrong");

	property p_line;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		($fell(burst_done_n_out) && s.last == 2'h3) |-> !burst_done_n_out [*4];
	endproperty
	a_line: assert property (p_line) else $error("line fill not one dword per clock");

	property p_toggle;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(s.st == ST_RD && $past(s.st) == ST_RD) |-> (data_sel_out != $past(data_sel_out));
	endproperty
	a_toggle: assert property (p_toggle) else $error("data select did not toggle");

	property p_dly;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		##2 (delayed_row_strobe_n_out == $past(&row_strobe_n_out, 2));
	endproperty
	a_dly: assert property (p_dly) else $error("delayed row strobe lag wrong");

	property p_row_path;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		delayed_row_strobe_n_out |-> (bank0_addr_out == s.row_reg[9:1]
			&& bank1_low_col_out == s.row_reg[0]);
	endproperty
	a_row_path: assert property (p_row_path) else $error("row path not selected");

	property p_hold;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		addr_hold_en_out |=> $stable(s.hold_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved while held");

	property p_reset;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		$rose(rst_b_in) |-> (&row_strobe_n_out && &col_strobe_n_out && !s.row_v && !s.wr_v);
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : idpw_ctrl

// ### include/idpw_defines.svh
// offsets, field positions, reset values and timing counts of the dram front end
`ifndef IDPW_DEFINES_SVH
`define IDPW_DEFINES_SVH

`define IDPW_OFF_CTRL 12'h000
`define IDPW_OFF_STAT 12'h004

`define IDPW_CTRL_ORG_1M 0
`define IDPW_CTRL_TWO_PAIRS 1
`define IDPW_CTRL_RST 2'h0

`define IDPW_STAT_HOLD 0
`define IDPW_STAT_WPEND 1
`define IDPW_STAT_ROWV 2
`define IDPW_STAT_BUSY 3

`define IDPW_CLK_NS 10
`define IDPW_ROW_DLY_NS 20
`define IDPW_ROW_DLY_CYC ((`IDPW_ROW_DLY_NS + `IDPW_CLK_NS - 1) / `IDPW_CLK_NS)
`define IDPW_PRE_CYC 2'h1
`define IDPW_LINE_LAST 2'h3

`endif

// ### include/idpw_pkg.sv
// state types of the interleaved dram front end
`include "idpw_defines.svh"

package idpw_pkg;

	typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_ROW, ST_RD, ST_WR} idpw_st_t;

	typedef struct packed {
		logic hold_v;
		logic hold_wr;
		logic hold_line;
		logic [21:0] hold_addr;
		logic [3:0] hold_be;
		logic wr_v;
		logic [21:0] wr_addr;
		logic [3:0] wr_be;
		logic [31:0] wr_data;
		idpw_st_t st;
		logic [1:0] cnt;
		logic [1:0] last;
		logic [1:0] wait_c;
		logic [1:0] ras_n;
		logic [`IDPW_ROW_DLY_CYC-1:0] dly;
		logic row_v;
		logic [10:0] row_reg;
		logic rd_cas;
		logic cdone_n;
		logic bdone_n;
		logic [1:0] cas_n;
		logic we_n;
		logic [3:0] be_n;
		logic [1:0][8:0] addr;
		logic [1:0] low;
		logic [1:0] path_n;
		logic rle;
		logic same_n;
		logic dsel;
		logic [31:0] rd_data;
		logic hold_en;
		logic [1:0] cfg;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} idpw_s_t;

endpackage : idpw_pkg

// ### test/idpw_cpu_model.sv
// processor bus model: posted writes and line fill reads
`timescale 1ns/1ps

module idpw_cpu_model (
	// clock
	input wire logic clk_sys_in,
	// request side
	output logic addr_strobe_n_out,
	output logic [21:0] cpu_addr_out,
	output logic [3:0] cpu_be_n_out,
	output logic cpu_write_out,
	output logic cpu_line_out,
	output logic [31:0] cpu_wdata_out,
	// answer side
	input wire logic cycle_done_n_in,
	input wire logic burst_done_n_in,
	input wire logic [31:0] cpu_rdata_in
);
	initial begin
		addr_strobe_n_out = 1'b1;
		cpu_addr_out = 22'h3fffff;
		cpu_be_n_out = 4'hf;
		cpu_write_out = 1'b0;
		cpu_line_out = 1'b0;
		cpu_wdata_out = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// one strobe cycle, then the address bus carries the inverted address
	task automatic start(input logic [21:0] a, input logic wr, input logic line);
		addr_strobe_n_out <= 1'b0;
		cpu_addr_out <= a;
		cpu_be_n_out <= 4'h0;
		cpu_write_out <= wr;
		cpu_line_out <= line;
		@(posedge clk_sys_in);
		addr_strobe_n_out <= 1'b1;
		cpu_addr_out <= ~a;
		cpu_be_n_out <= 4'hf;
	endtask : start

	// next strobe may follow in the clock after done
	task automatic write_cycle(input logic [21:0] a, input logic [31:0] d, output int lat);
		start(a, 1'b1, 1'b0);
		cpu_wdata_out <= d;
		lat = 1;
		do begin
			@(posedge clk_sys_in);
			lat++;
		end while (cycle_done_n_in !== 1'b0 && lat < 40);
		cpu_wdata_out <= ~d;
	endtask : write_cycle

	// gaps in the burst show up as unknown data
	task automatic read_line(input logic [21:0] a, output logic [31:0] q [4], output int lat);
		start(a, 1'b0, 1'b1);
		lat = 1;
		do begin
			@(posedge clk_sys_in);
			lat++;
		end while (burst_done_n_in !== 1'b0 && lat < 40);
		q[0] = cpu_rdata_in;
		for (int i = 1; i < 4; i++) begin
			@(posedge clk_sys_in);
			q[i] = (burst_done_n_in === 1'b0) ? cpu_rdata_in : 32'hx;
		end
	endtask : read_line
endmodule : idpw_cpu_model

// ### test/idpw_ctrl_bench.sv
// self-checking bench of the interleaved dram front end
`timescale 1ns/1ps

`define IDPW_CHK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
	end \
end

module idpw_ctrl_bench;
	logic clk_sys_in, rst_b_in, psel_in, penable_in, pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, cpu_rdata_out, dram_wdata_out, b0_rd, b1_rd;
	logic pready_out, pslverr_out, as_n, wr, line, cdone_n, bdone_n, hold_en;
	logic [21:0] addr;
	logic [3:0] be_n;
	logic [31:0] wdata;
	logic [1:0] ras_n, cas_n;
	logic delayed_row_strobe_n_n, we_n, p0_n, p1_n;
	logic [8:0] a0, a1;
	logic [3:0] dbe_n;
	logic same_n;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;

	// bank data carries its bank in the upper half
	assign b0_rd = {16'hb0b0, 7'h00, a0};
	assign b1_rd = {16'hb1b1, 7'h00, a1};

	idpw_ctrl u_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .addr_strobe_n_in(as_n), .cpu_addr_in(addr),
		.cpu_be_n_in(be_n), .cpu_write_in(wr), .cpu_line_in(line), .cpu_wdata_in(wdata),
		.cpu_rdata_out(cpu_rdata_out), .cycle_done_n_out(cdone_n),
		.burst_done_n_out(bdone_n), .addr_hold_en_out(hold_en), .same_row_n_out(same_n),
		.data_sel_out(), .bank0_rdata_in(b0_rd), .bank1_rdata_in(b1_rd),
		.row_strobe_n_out(ras_n), .delayed_row_strobe_n_out(delayed_row_strobe_n_n),
		.col_strobe_n_out(cas_n), .write_en_n_out(we_n), .dram_be_n_out(dbe_n),
		.dram_wdata_out(dram_wdata_out), .bank0_addr_out(a0), .bank1_addr_out(a1),
		.bank0_low_col_out(), .bank1_low_col_out(), .bank0_path_sel_n_out(p0_n),
		.bank1_path_sel_n_out(p1_n), .row_latch_en_out());

	idpw_cpu_model u_cpu (.clk_sys_in(clk_sys_in), .addr_strobe_n_out(as_n),
		.cpu_addr_out(addr), .cpu_be_n_out(be_n), .cpu_write_out(wr),
		.cpu_line_out(line), .cpu_wdata_out(wdata), .cycle_done_n_in(cdone_n),
		.burst_done_n_in(bdone_n), .cpu_rdata_in(cpu_rdata_out));

	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		q = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask : apb

	task automatic t_reset;
		`IDPW_CHK(ras_n, 2'b11)
		`IDPW_CHK(cas_n, 2'b11)
		`IDPW_CHK({cdone_n, bdone_n, p0_n, p1_n, hold_en}, 5'h1e)
	endtask : t_reset

	task automatic t_apb;
		logic [31:0] q;
		logic e;
		apb(1'b1, 12'h000, 32'h2, q, e);
		apb(1'b0, 12'h000, 32'h0, q, e);
		`IDPW_CHK({e, q}, 33'h2)
		apb(1'b0, 12'h008, 32'h0, q, e);
		`IDPW_CHK({e, q}, 33'h100000000)
		apb(1'b1, 12'h000, 32'h0, q, e);
	endtask : t_apb

	task automatic t_write;
		int lat;
		u_cpu.write_cycle(22'h000010, 32'h11112222, lat);
		repeat (14) @(posedge clk_sys_in);
		u_cpu.write_cycle(22'h000011, 32'h5a5a0f0f, lat);
		`IDPW_CHK(lat, 2)
		`IDPW_CHK(hold_en, 1'b1)
		repeat (2) @(posedge clk_sys_in);
		`IDPW_CHK(cas_n, 2'b01)
		`IDPW_CHK(we_n, 1'b0)
		`IDPW_CHK(dram_wdata_out, 32'h5a5a0f0f)
		`IDPW_CHK({p0_n, p1_n}, 2'b10)
		`IDPW_CHK({delayed_row_strobe_n_n, ras_n[0]}, 2'b00)
		`IDPW_CHK(dbe_n, 4'h0)
		`IDPW_CHK(same_n, 1'b0)
	endtask : t_write

	task automatic t_b2b;
		int lat;
		for (int i = 0; i < 4; i++) begin
			u_cpu.write_cycle(22'h000020 + 22'(i), 32'hc0de0000 + i, lat);
			`IDPW_CHK(lat, 2)
		end
		repeat (4) @(posedge clk_sys_in);
		`IDPW_CHK(dram_wdata_out, 32'hc0de0003)
	endtask : t_b2b

	task automatic t_line;
		logic [31:0] q [4];
		int lat;
		logic [1:0] s;
		for (int k = 0; k < 2; k++) begin
			s = k ? 2'b10 : 2'b01;
			repeat (6) @(posedge clk_sys_in);
			u_cpu.read_line({20'h000c, s}, q, lat);
			`IDPW_CHK(lat, 3)
			for (int i = 0; i < 4; i++)
				`IDPW_CHK(q[i][31:16], (s[0] ^ i[0]) ? 16'hb1b1 : 16'hb0b0)
		end
	endtask : t_line

	initial begin
		rst_b_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 12'h000;
		pwdata_in = 32'h0;
		repeat (6) @(posedge clk_sys_in);
		t_reset();
		rst_b_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		t_apb();
		t_write();
		t_b2b();
		t_line();
		conclude();
	end
endmodule : idpw_ctrl_bench
